// *** logic/ccs_defs.vh ***
// constants, register map and field positions of the channel control and status registers
// Function
// - a channel enable bit of 0 powers down the channel's clock recovery and LVDS I/O, 1 runs it.
// - a powered-down channel together with the receive data enable input floats its parallel data output bus.
// - control bit 6 is the 3-state control of the channel's parallel data output.
// - control bit 7 is the 3-state control of the overhead data output, channel A only.
// - transmit mode bit 0 inserts overhead from the serial ports, 1 passes all overhead through.
// - each per-byte source bit inserts its overhead byte when 0 and passes it through when 1.
// - the framing error command corrupts A1/A2 for the frame count held in global register 0C.
// - the B1 error command corrupts the B1 bits chosen by global register 0F for one frame.
// - framing error insertion starts on a rising edge of its command bit, which must return to 0.
// - B1 error insertion starts on a rising edge of its command bit, which must return to 0.
// - a concatenation status bit reads 1 for a concatenated member and 0 otherwise or for a head.
// - the summary register shows alarm, path AIS and elastic store overflow with a 3-bit mask.
// - the alarm register flags six conditions, each qualified by a bit of a 6-bit mask.
// - one path AIS flag per STS is kept in two registers, each with a matching mask register.
`ifndef CCS_DEFS_VH
`define CCS_DEFS_VH
// register indices; the byte address is four times the index
`define CCS_IDX_A1A2_FRAMES 6'h0C
`define CCS_IDX_B1_SELECT   6'h0F
`define CCS_IDX_CTRL        6'h20
`define CCS_IDX_TX_SRC      6'h21
`define CCS_IDX_TX_D_SRC    6'h22
`define CCS_IDX_ERR_CMD     6'h23
`define CCS_IDX_CONCAT_HI   6'h24
`define CCS_IDX_CONCAT_LO   6'h25
`define CCS_IDX_SUMMARY     6'h26
`define CCS_IDX_SUM_MASK    6'h27
`define CCS_IDX_ALARM       6'h28
`define CCS_IDX_ALARM_MASK  6'h29
`define CCS_IDX_AIS_HI      6'h2A
`define CCS_IDX_AIS_LO      6'h2B
`define CCS_IDX_AIS_MASK_HI 6'h2C
`define CCS_IDX_AIS_MASK_LO 6'h2D
// field positions
`define CCS_CTRL_ENABLE     5
`define CCS_CTRL_PAR_HIZ    6
`define CCS_CTRL_TOH_HIZ    7
`define CCS_TX_PASS_ALL     7
`define CCS_CMD_A1A2        0
`define CCS_CMD_B1          1
`define CCS_SUM_ALARM       0
`define CCS_SUM_AIS         1
`define CCS_SUM_ES_OVF      2
// widths
`define CCS_W_SUM           3
`define CCS_W_ALARM         6
`define CCS_W_AIS_HI        4
`define CCS_W_AIS_LO        8
`define CCS_W_TX_SEL        15
// byte lane offset that a mapped access must carry
`define CCS_ALIGNED         2'b00
// frame counter step
`define CCS_CNT_STEP        8'h01
`define CCS_RESET_BYTE      8'h00
`define CCS_ZERO_WORD       32'h0000_0000
`endif

// *** logic/ccs_regs.v ***
// channel control and status register bank with APB slave and interrupt output
//
// Chosen here: the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "ccs_defs.vh"
module ccs_regs (
   input  wire        i_core_clk,
   input  wire        i_sys_rst,
   input  wire        i_psel,
   input  wire        i_penable,
   input  wire        i_pwrite,
   input  wire [7:0]  i_paddr,
   input  wire [31:0] i_pwdata,
   output reg  [31:0] o_prdata,
   output wire        o_pready,
   output reg         o_pslverr,
   input  wire        i_data_rx_en,
   input  wire        i_frame_sync,
   input  wire [11:0] i_concat_member,
   input  wire [5:0]  i_alarm_event,
   input  wire [3:0]  i_ais_event_hi,
   input  wire [7:0]  i_ais_event_lo,
   input  wire        i_es_ovf_event,
   output reg         o_cdr_lvds_pwr_en,
   output reg         o_par_out_hiz,
   output reg         o_toh_out_hiz,
   output reg  [14:0] o_tx_pass_sel,
   output reg         o_a1a2_corrupt,
   output reg         o_b1_corrupt,
   output reg  [7:0]  o_b1_corrupt_bits,
   output wire        o_irq
);

   // control registers
   reg  [7:0]  ctrl_q;
   reg  [7:0]  tx_src_q;
   reg  [7:0]  tx_d_src_q;
   reg  [1:0]  err_cmd_q;
   reg  [1:0]  err_cmd_prev_q;
   reg  [7:0]  a1a2_frames_q;
   reg  [7:0]  b1_select_q;
   reg  [2:0]  sum_mask_q;
   reg  [5:0]  alarm_mask_q;
   reg  [3:0]  ais_mask_hi_q;
   reg  [7:0]  ais_mask_lo_q;

   // status registers
   reg  [11:0] concat_q;
   reg  [5:0]  alarm_q;
   reg  [5:0]  alarm_d;
   reg  [3:0]  ais_hi_q;
   reg  [3:0]  ais_hi_d;
   reg  [7:0]  ais_lo_q;
   reg  [7:0]  ais_lo_d;
   reg         es_ovf_q;
   reg         es_ovf_d;

   // error insertion state
   reg         a1a2_pend_q;
   reg  [7:0]  a1a2_cnt_q;
   reg         b1_pend_q;

   // receive enable pin synchroniser
   reg         rx_en_meta_q;
   reg         rx_en_sync_q;

   wire [5:0]  idx;
   wire        setup;
   wire        wr_acc;
   wire [7:0]  wbyte;
   wire [2:0]  summary;
   wire        a1a2_rise;
   wire        b1_rise;
   reg  [7:0]  rd_byte;
   reg         rd_hit;

   assign idx   = i_paddr[7:2];
   assign setup = i_psel & ~i_penable;
   assign wr_acc = i_psel & i_penable & i_pwrite;
   assign wbyte = i_pwdata[7:0];
   assign o_pready = 1'b1;

   // summary flags consolidate the masked alarm and AIS groups and the unmasked overflow flag
   assign summary[`CCS_SUM_ALARM]  = |(alarm_q & alarm_mask_q);
   assign summary[`CCS_SUM_AIS]    = |({ais_hi_q, ais_lo_q} & {ais_mask_hi_q, ais_mask_lo_q});
   assign summary[`CCS_SUM_ES_OVF] = es_ovf_q;

   // level interrupt while an enabled summary flag is set
   assign o_irq = |(summary & sum_mask_q);

   // insertion starts only on a 0 to 1 step of the command bit
   assign a1a2_rise = err_cmd_q[`CCS_CMD_A1A2] & ~err_cmd_prev_q[`CCS_CMD_A1A2];
   assign b1_rise   = err_cmd_q[`CCS_CMD_B1] & ~err_cmd_prev_q[`CCS_CMD_B1];

   always @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         rx_en_meta_q <= 1'b0;
         rx_en_sync_q <= 1'b0;
      end else begin
         rx_en_meta_q <= i_data_rx_en;
         rx_en_sync_q <= rx_en_meta_q;
      end
   end

   // read mux
   always @* begin
      rd_byte = `CCS_RESET_BYTE;
      rd_hit  = 1'b1;
      case (idx)
         `CCS_IDX_A1A2_FRAMES: rd_byte = a1a2_frames_q;
         `CCS_IDX_B1_SELECT:   rd_byte = b1_select_q;
         `CCS_IDX_CTRL:        rd_byte = ctrl_q;
         `CCS_IDX_TX_SRC:      rd_byte = tx_src_q;
         `CCS_IDX_TX_D_SRC:    rd_byte = tx_d_src_q;
         `CCS_IDX_ERR_CMD:     rd_byte = {6'h00, err_cmd_q};
         `CCS_IDX_CONCAT_HI:   rd_byte = {4'h0, concat_q[11:8]};
         `CCS_IDX_CONCAT_LO:   rd_byte = concat_q[7:0];
         `CCS_IDX_SUMMARY:     rd_byte = {5'h00, summary};
         `CCS_IDX_SUM_MASK:    rd_byte = {5'h00, sum_mask_q};
         `CCS_IDX_ALARM:       rd_byte = {2'h0, alarm_q};
         `CCS_IDX_ALARM_MASK:  rd_byte = {2'h0, alarm_mask_q};
         `CCS_IDX_AIS_HI:      rd_byte = {4'h0, ais_hi_q};
         `CCS_IDX_AIS_LO:      rd_byte = ais_lo_q;
         `CCS_IDX_AIS_MASK_HI: rd_byte = {4'h0, ais_mask_hi_q};
         `CCS_IDX_AIS_MASK_LO: rd_byte = ais_mask_lo_q;
         default: begin
            rd_byte = `CCS_RESET_BYTE;
            rd_hit  = 1'b0;
         end
      endcase
   end

   // read data and error are captured in the setup cycle, valid in the access cycle
   always @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         o_prdata  <= `CCS_ZERO_WORD;
         o_pslverr <= 1'b0;
      end else if (setup) begin
         o_prdata  <= i_pwrite ? `CCS_ZERO_WORD : {24'h00_0000, rd_byte};
         o_pslverr <= ~rd_hit | (i_paddr[1:0] != `CCS_ALIGNED);
      end else if (!i_psel) begin
         o_pslverr <= 1'b0;
      end
   end

   // writable controls, all zero after reset
   always @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         ctrl_q         <= `CCS_RESET_BYTE;
         tx_src_q       <= `CCS_RESET_BYTE;
         tx_d_src_q     <= `CCS_RESET_BYTE;
         err_cmd_q      <= 2'b00;
         err_cmd_prev_q <= 2'b00;
         a1a2_frames_q  <= `CCS_RESET_BYTE;
         b1_select_q    <= `CCS_RESET_BYTE;
         sum_mask_q     <= 3'b000;
         alarm_mask_q   <= 6'h00;
         ais_mask_hi_q  <= 4'h0;
         ais_mask_lo_q  <= `CCS_RESET_BYTE;
      end else begin
         err_cmd_prev_q <= err_cmd_q;
         if (wr_acc && i_paddr[1:0] == `CCS_ALIGNED) begin
            case (idx)
               `CCS_IDX_A1A2_FRAMES: a1a2_frames_q <= wbyte;
               `CCS_IDX_B1_SELECT:   b1_select_q   <= wbyte;
               `CCS_IDX_CTRL:        ctrl_q        <= wbyte;
               `CCS_IDX_TX_SRC:      tx_src_q      <= wbyte;
               `CCS_IDX_TX_D_SRC:    tx_d_src_q    <= wbyte;
               `CCS_IDX_ERR_CMD:     err_cmd_q     <= wbyte[1:0];
               `CCS_IDX_SUM_MASK:    sum_mask_q    <= wbyte[2:0];
               `CCS_IDX_ALARM_MASK:  alarm_mask_q  <= wbyte[5:0];
               `CCS_IDX_AIS_MASK_HI: ais_mask_hi_q <= wbyte[3:0];
               `CCS_IDX_AIS_MASK_LO: ais_mask_lo_q <= wbyte;
               default: begin
                  ctrl_q <= ctrl_q;
               end
            endcase
         end
      end
   end

   // sticky flags: write one to clear, a new event in the same cycle wins
   always @* begin
      alarm_d  = alarm_q | i_alarm_event;
      ais_hi_d = ais_hi_q | i_ais_event_hi;
      ais_lo_d = ais_lo_q | i_ais_event_lo;
      es_ovf_d = es_ovf_q | i_es_ovf_event;
      if (wr_acc && i_paddr[1:0] == `CCS_ALIGNED) begin
         case (idx)
            `CCS_IDX_ALARM:   alarm_d  = (alarm_q & ~wbyte[5:0]) | i_alarm_event;
            `CCS_IDX_AIS_HI:  ais_hi_d = (ais_hi_q & ~wbyte[3:0]) | i_ais_event_hi;
            `CCS_IDX_AIS_LO:  ais_lo_d = (ais_lo_q & ~wbyte) | i_ais_event_lo;
            `CCS_IDX_SUMMARY: es_ovf_d = (es_ovf_q & ~wbyte[`CCS_SUM_ES_OVF])
                                         | i_es_ovf_event;
            default: begin
               es_ovf_d = es_ovf_q | i_es_ovf_event;
            end
         endcase
      end
   end

   always @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         alarm_q  <= 6'h00;
         ais_hi_q <= 4'h0;
         ais_lo_q <= `CCS_RESET_BYTE;
         es_ovf_q <= 1'b0;
         concat_q <= 12'h000;
      end else begin
         alarm_q  <= alarm_d;
         ais_hi_q <= ais_hi_d;
         ais_lo_q <= ais_lo_d;
         es_ovf_q <= es_ovf_d;
         concat_q <= i_concat_member;
      end
   end

   // framing error insertion: armed by the edge, runs for the programmed frame count
   always @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         a1a2_pend_q    <= 1'b0;
         a1a2_cnt_q     <= `CCS_RESET_BYTE;
         o_a1a2_corrupt <= 1'b0;
      end else begin
         if (a1a2_rise) begin
            a1a2_pend_q <= 1'b1;
         end else if (i_frame_sync && a1a2_pend_q) begin
            a1a2_pend_q <= 1'b0;
         end
         if (i_frame_sync) begin
            if (a1a2_pend_q) begin
               a1a2_cnt_q     <= a1a2_frames_q;
               o_a1a2_corrupt <= (a1a2_frames_q != `CCS_RESET_BYTE);
            end else if (a1a2_cnt_q != `CCS_RESET_BYTE) begin
               a1a2_cnt_q     <= a1a2_cnt_q - `CCS_CNT_STEP;
               o_a1a2_corrupt <= (a1a2_cnt_q != `CCS_CNT_STEP);
            end else begin
               o_a1a2_corrupt <= 1'b0;
            end
         end
      end
   end

   // B1 error insertion: one frame with the selected parity bits
   always @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         b1_pend_q         <= 1'b0;
         o_b1_corrupt      <= 1'b0;
         o_b1_corrupt_bits <= `CCS_RESET_BYTE;
      end else begin
         if (b1_rise) begin
            b1_pend_q <= 1'b1;
         end else if (i_frame_sync && b1_pend_q) begin
            b1_pend_q <= 1'b0;
         end
         if (i_frame_sync) begin
            o_b1_corrupt      <= b1_pend_q;
            o_b1_corrupt_bits <= b1_pend_q ? b1_select_q : `CCS_RESET_BYTE;
         end
      end
   end

   // channel controls driven from registers
   always @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         o_cdr_lvds_pwr_en <= 1'b0;
         o_par_out_hiz     <= 1'b0;
         o_toh_out_hiz     <= 1'b0;
         o_tx_pass_sel     <= 15'h0000;
      end else begin
         o_cdr_lvds_pwr_en <= ctrl_q[`CCS_CTRL_ENABLE];
         o_par_out_hiz     <= ctrl_q[`CCS_CTRL_PAR_HIZ]
                              | (~ctrl_q[`CCS_CTRL_ENABLE] & rx_en_sync_q);
         o_toh_out_hiz     <= ctrl_q[`CCS_CTRL_TOH_HIZ];
         // pass-all forces every byte through, else each bit picks its byte
         o_tx_pass_sel     <= {tx_src_q[6:0], tx_d_src_q}
                              | {`CCS_W_TX_SEL{tx_src_q[`CCS_TX_PASS_ALL]}};
      end
   end

endmodule
`default_nettype wire

// *** tb/ccs_regs_monitor.sv ***
// assertion checker for the channel register bank
`timescale 1ns/100ps
`default_nettype none
`include "ccs_defs.vh"
module ccs_regs_monitor (
   input wire logic        i_core_clk,
   input wire logic        i_sys_rst,
   input wire logic        i_psel,
   input wire logic        i_penable,
   input wire logic        i_pwrite,
   input wire logic [7:0]  i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic        i_frame_sync,
   input wire logic        o_pready,
   input wire logic        o_pslverr,
   input wire logic        o_cdr_lvds_pwr_en,
   input wire logic        o_par_out_hiz,
   input wire logic        o_toh_out_hiz,
   input wire logic [14:0] o_tx_pass_sel,
   input wire logic        o_a1a2_corrupt,
   input wire logic        o_b1_corrupt,
   input wire logic        o_irq
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_sys_rst);
   sequence s_wr(logic [5:0] a);
      i_psel && i_penable && i_pwrite && i_paddr == {a, 2'b00};
   endsequence
   sequence s_b1_end;
      o_b1_corrupt && i_frame_sync;
   endsequence
   chk_pwr_follow: assert property (s_wr(`CCS_IDX_CTRL) |->
      ##2 o_cdr_lvds_pwr_en == $past(i_pwdata[5], 2)) else $error("power enable stale");
   chk_par_hiz: assert property (s_wr(`CCS_IDX_CTRL) && i_pwdata[6] |->
      ##2 o_par_out_hiz) else $error("parallel bus driven");
   chk_toh_hiz: assert property (s_wr(`CCS_IDX_CTRL) |->
      ##2 o_toh_out_hiz == $past(i_pwdata[7], 2)) else $error("overhead hi-z stale");
   chk_pass_all: assert property (s_wr(`CCS_IDX_TX_SRC) && i_pwdata[7] |->
      ##2 o_tx_pass_sel == 15'h7fff) else $error("pass-through not total");
   chk_b1_hold: assert property (o_b1_corrupt && !i_frame_sync |=> o_b1_corrupt)
      else $error("b1 corruption cut short");
   chk_b1_end: assert property (s_b1_end |=> !o_b1_corrupt)
      else $error("b1 corruption too long");
   chk_a1a2_edges: assert property ($changed(o_a1a2_corrupt) |-> $past(i_frame_sync))
      else $error("a1a2 corruption off frame");
   chk_bad_addr: assert property (i_psel && !i_penable && (i_paddr[1:0] != 2'b00
      || i_paddr[7:2] == 6'h3f) |=> o_pready && o_pslverr) else $error("no slave error");
   chk_reset_quiet: assert property ($fell(i_sys_rst) |-> !o_irq && !o_b1_corrupt
      && !o_a1a2_corrupt && !o_cdr_lvds_pwr_en) else $error("outputs busy after reset");
endmodule
bind ccs_regs ccs_regs_monitor i_ccs_regs_monitor (.i_core_clk(i_core_clk),
   .i_sys_rst(i_sys_rst), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
   .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_frame_sync(i_frame_sync),
   .o_pready(o_pready), .o_pslverr(o_pslverr), .o_cdr_lvds_pwr_en(o_cdr_lvds_pwr_en),
   .o_par_out_hiz(o_par_out_hiz), .o_toh_out_hiz(o_toh_out_hiz),
   .o_tx_pass_sel(o_tx_pass_sel), .o_a1a2_corrupt(o_a1a2_corrupt),
   .o_b1_corrupt(o_b1_corrupt), .o_irq(o_irq));
`default_nettype wire

// *** tb/ccs_host_model.sv ***
// bus master standing in for the array logic on the register port
`timescale 1ns/100ps
`default_nettype none
module ccs_host_model (
   input  wire logic        i_core_clk,
   input  wire logic [31:0] i_prdata,
   input  wire logic        i_pready,
   input  wire logic        i_pslverr,
   output var  logic        o_psel,
   output var  logic        o_penable,
   output var  logic        o_pwrite,
   output var  logic [7:0]  o_paddr,
   output var  logic [31:0] o_pwdata
);
   initial {o_psel, o_penable, o_pwrite, o_paddr, o_pwdata} = '0;
   task automatic xfer(input logic w, input logic [5:0] idx, input logic [7:0] d,
                       output logic [31:0] rd, output logic err);
      o_psel <= 1'b1;
      o_pwrite <= w;
      o_paddr <= {idx, 2'b00};
      o_pwdata <= {24'h00_0000, d};
      @(posedge i_core_clk);
      o_penable <= 1'b1;
      do
         @(posedge i_core_clk);
      while (i_pready !== 1'b1);
      rd = i_prdata;
      err = i_pslverr;
      o_psel <= 1'b0;
      o_penable <= 1'b0;
      // released data lines must not keep showing the last word
      o_pwdata <= ~o_pwdata;
      repeat (2) @(posedge i_core_clk);
   endtask
endmodule
`default_nettype wire

// *** tb/ccs_regs_tb.sv ***
// self-checking bench for the channel register bank
`timescale 1ns/100ps
`default_nettype none
`include "ccs_defs.vh"
module ccs_regs_tb;
   localparam logic [21:0] ROWS [0:8] = '{{`CCS_IDX_CTRL, 8'he0, 8'he0},
      {`CCS_IDX_TX_SRC, 8'h5a, 8'h5a}, {`CCS_IDX_TX_D_SRC, 8'h3c, 8'h3c},
      {`CCS_IDX_SUM_MASK, 8'hff, 8'h07}, {`CCS_IDX_ALARM_MASK, 8'hff, 8'h3f},
      {`CCS_IDX_AIS_MASK_HI, 8'hff, 8'h0f}, {`CCS_IDX_AIS_MASK_LO, 8'hff, 8'hff},
      {`CCS_IDX_A1A2_FRAMES, 8'h02, 8'h02}, {`CCS_IDX_B1_SELECT, 8'h81, 8'h81}};
   localparam logic [10:0] CTL [0:3] = '{{8'h00, 3'b010}, {8'h20, 3'b100},
      {8'h60, 3'b110}, {8'ha0, 3'b101}};
   logic             i_core_clk = 1'b0, i_sys_rst = 1'b1, i_data_rx_en = 1'b0;
   logic             i_frame_sync = 1'b0, rerr;
   logic [11:0]      i_concat_member = 12'h000;
   logic [18:0]      ev = 19'h0_0000;
   logic [31:0]      rdat, na, nb, bits_seen;
   wire logic        psel, penable, pwrite, pready, pslverr, pwr, par, toh, a1a2, b1, irq;
   wire logic [7:0]  paddr, b1_bits;
   wire logic [31:0] pwdata, prdata;
   wire logic [14:0] pass_sel;
   int               error_cnt = 0, samples_checked = 0;
   ccs_regs i_ccs_regs (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_data_rx_en(i_data_rx_en),
      .i_frame_sync(i_frame_sync), .i_concat_member(i_concat_member), .i_alarm_event(ev[5:0]),
      .i_ais_event_hi(ev[9:6]), .i_ais_event_lo(ev[17:10]), .i_es_ovf_event(ev[18]),
      .o_cdr_lvds_pwr_en(pwr), .o_par_out_hiz(par), .o_toh_out_hiz(toh), .o_irq(irq),
      .o_tx_pass_sel(pass_sel), .o_a1a2_corrupt(a1a2), .o_b1_corrupt(b1),
      .o_b1_corrupt_bits(b1_bits));
   ccs_host_model i_ccs_host_model (.i_core_clk(i_core_clk), .i_prdata(prdata),
      .i_pready(pready), .i_pslverr(pslverr), .o_psel(psel), .o_penable(penable),
      .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata));
   always #2 i_core_clk = ~i_core_clk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [5:0] a, input logic [7:0] e);
      i_ccs_host_model.xfer(1'b0, a, 8'h00, rdat, rerr);
      chk(rdat, {24'h00_0000, e});
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      i_ccs_host_model.xfer(1'b1, a, d, rdat, rerr);
   endtask
   task automatic pulse(input logic [18:0] v);
      ev <= v;
      @(posedge i_core_clk);
      ev <= 19'h0_0000;
      repeat (2) @(posedge i_core_clk);
   endtask
   // one frame is four clocks; corruption clocks are counted as they pass
   task automatic frame();
      for (int k = 0; k < 4; k++) begin
         i_frame_sync <= (k == 0);
         @(posedge i_core_clk);
         na += a1a2;
         nb += b1;
         if (b1 === 1'b1)
            bits_seen = b1_bits;
      end
   endtask
   task automatic conclude();
      $display("checks=%0d errors=%0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      #40000;
      error_cnt++;
      conclude();
   end
   initial begin
      repeat (2) @(posedge i_core_clk);
      i_sys_rst <= 1'b0;
      @(posedge i_core_clk);
      for (int a = 6'h23; a < 6'h2c; a++) rd(a[5:0], 8'h00);
      foreach (ROWS[k]) begin
         rd(ROWS[k][21:16], 8'h00);
         wr(ROWS[k][21:16], ROWS[k][15:8]);
         rd(ROWS[k][21:16], ROWS[k][7:0]);
      end
      chk(pass_sel, 15'h5a3c);
      i_data_rx_en <= 1'b1;
      foreach (CTL[k]) begin
         wr(`CCS_IDX_CTRL, CTL[k][10:3]);
         repeat (4) @(posedge i_core_clk);
         chk({pwr, par, toh}, CTL[k][2:0]);
      end
      wr(`CCS_IDX_TX_SRC, 8'h80);
      chk(pass_sel, 15'h7fff);
      {na, nb, bits_seen} = '0;
      wr(`CCS_IDX_ERR_CMD, 8'h01);
      repeat (5) frame();
      chk(na, 32'h0000_0008);
      wr(`CCS_IDX_ERR_CMD, 8'h01);
      repeat (3) frame();
      chk(na, 32'h0000_0008);
      wr(`CCS_IDX_ERR_CMD, 8'h00);
      wr(`CCS_IDX_ERR_CMD, 8'h02);
      repeat (3) frame();
      chk(nb, 32'h0000_0004);
      chk(bits_seen, 32'h0000_0081);
      wr(`CCS_IDX_ERR_CMD, 8'h02);
      repeat (2) frame();
      chk(nb, 32'h0000_0004);
      pulse(19'h0_0004);
      rd(`CCS_IDX_ALARM, 8'h04);
      rd(`CCS_IDX_SUMMARY, 8'h01);
      chk(irq, 1'b1);
      wr(`CCS_IDX_ALARM_MASK, 8'h00);
      chk(irq, 1'b0);
      wr(`CCS_IDX_ALARM, 8'h04);
      rd(`CCS_IDX_ALARM, 8'h00);
      pulse(19'h4_0000);
      rd(`CCS_IDX_SUMMARY, 8'h04);
      wr(`CCS_IDX_SUMMARY, 8'h04);
      pulse(19'h0_0400);
      rd(`CCS_IDX_AIS_LO, 8'h01);
      rd(`CCS_IDX_SUMMARY, 8'h02);
      i_concat_member <= 12'ha5c;
      repeat (2) @(posedge i_core_clk);
      rd(`CCS_IDX_CONCAT_HI, 8'h0a);
      rd(`CCS_IDX_CONCAT_LO, 8'h5c);
      rd(6'h3f, 8'h00);
      chk(rerr, 1'b1);
      conclude();
   end
endmodule
`default_nettype wire
